// ### verilog/nscw_pkg.sv
// Shared constants for the normal-space wait-cycle controller
`default_nettype none
package nscw_pkg;
	// ==================================================
	// Register map
	localparam int ADDR_W = 8;
	localparam logic [7:0] OFF_AREA2 = 8'h00;
	localparam logic [7:0] OFF_AREA3 = 8'h04;
	localparam logic [7:0] OFF_AREA4 = 8'h08;
	localparam logic [7:0] OFF_AREA5A = 8'h0C;
	localparam logic [7:0] OFF_STATUS = 8'h10;
	// ==================================================
	// Field layout
	localparam int WR_LSB = 7;
	localparam int WM_BIT = 6;
	localparam int SW_LSB = 11;
	localparam int WW_LSB = 16;
	localparam logic [31:0] MASK_AREA23 = 32'h0000_07C0;
	localparam logic [31:0] MASK_AREA45 = 32'h0007_1FC0;
	localparam logic [31:0] RST_WAIT = 32'h0000_0500;
	// ==================================================
	// Counting
	localparam int CNT_W = 5;
endpackage
`default_nettype wire

// ### verilog/nscw_wait_decode.sv
// Wait code to cycle count translation
`timescale 1ns/10ps
`default_nettype none
module nscw_wait_decode (
	// Codes
	input wire logic [3:0] wr_code,
	input wire logic [2:0] ww_code,
	input wire logic use_ww,
	// Result
	output logic [nscw_pkg::CNT_W-1:0] cycles
);
	always_comb begin
		if (use_ww && ww_code != 3'h0) begin
			cycles = {2'h0, ww_code} - 5'h01;
		end else begin
			case (wr_code)
				4'h7: cycles = 5'h08;
				4'h8: cycles = 5'h0A;
				4'h9: cycles = 5'h0C;
				4'hA: cycles = 5'h0E;
				4'hB: cycles = 5'h12;
				4'hC: cycles = 5'h18;
				// Prohibited codes fall back to the longest wait
				4'hD, 4'hE, 4'hF: cycles = 5'h18;
				default: cycles = {1'h0, wr_code};
			endcase
		end
	end
endmodule
`default_nettype wire

// ### verilog/nscw_down_counter.sv
// Loadable down counter
`timescale 1ns/10ps
`default_nettype none
module nscw_down_counter #(
	parameter int W = 5
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Control
	input wire logic load,
	input wire logic [W-1:0] load_val,
	input wire logic dec,
	// State
	output logic [W-1:0] count,
	output logic zero
);
	logic [W-1:0] next_count;

	always_comb begin
		next_count = count;
		if (load) begin
			next_count = load_val;
		end else if (dec && count != '0) begin
			next_count = count - W'(1);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count <= '0;
		end else begin
			count <= next_count;
		end
	end

	assign zero = (count == '0);
endmodule
`default_nettype wire

// ### verilog/nscw_ctrl.sv
// Wait-cycle configuration registers and external access sequencer
// What this block does
// - Stretch area 2/3 accesses by 4-bit wait code: 0-6, then 8,10,12,14,18,24.
// - Access wait field resets to 1010 in every wait register.
// - Mask bit 6 clear honours external wait; set ignores it.
// - External wait mask applies even when the wait count is zero.
// - Areas 4/5A writes use 3-bit code; 000 reuses read wait, else 0-6.
// - Areas 4/5A delay strobes after chip select by 0.5 to 3.5 cycles.
// - Reserved bits read zero and ignore writes.
//
// Local design decisions: register access over APB and the address map.
`timescale 1ns/10ps
`default_nettype none
module nscw_ctrl #(
	parameter int AW = 24,
	parameter int DW = 16
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic [nscw_pkg::ADDR_W-1:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Access requests
	input wire logic acc_req,
	input wire logic [1:0] acc_area,
	input wire logic acc_write,
	input wire logic [AW-1:0] acc_addr,
	input wire logic [DW-1:0] acc_wdata,
	output logic acc_ready,
	output logic acc_done,
	output logic [DW-1:0] acc_rdata,
	// External memory pins
	output logic [AW-1:0] ext_addr,
	output logic [3:0] area_chip_select_n,
	output logic ext_rd_n,
	output logic ext_we_n,
	output logic [DW-1:0] ext_data_o,
	output logic ext_data_oe_n,
	input wire logic [DW-1:0] ext_data_i,
	input wire logic ext_wait_n
);
	typedef enum logic [2:0] {ST_IDLE, ST_SETUP, ST_STROBE, ST_EXTWAIT, ST_END} nscw_state_e;

	// ==================================================
	// Registers over APB
	logic [31:0] cfg [4];
	logic [31:0] next_cfg [4];
	logic [31:0] rd_val;
	logic [31:0] next_prdata;
	logic hit;
	logic [1:0] idx;
	nscw_state_e state, next_state;
	logic [1:0] lat_area, next_area;
	logic lat_write, next_write;
	logic lat_mask, next_mask;
	logic [1:0] lat_setup, next_setup;

	assign idx = paddr[3:2];
	assign hit = (paddr[7:4] == 4'h0) && (paddr[1:0] == 2'h0);

	always_comb begin
		rd_val = 32'h0000_0000;
		if (hit) begin
			rd_val = cfg[idx];
		end else if (paddr == nscw_pkg::OFF_STATUS) begin
			rd_val = {27'h0, !ext_wait_n && state == ST_EXTWAIT, lat_area, state != ST_IDLE, 1'h0};
		end
		next_prdata = (psel && !penable && !pwrite) ? rd_val : prdata;
		for (int i = 0; i < 4; i++) begin
			next_cfg[i] = cfg[i];
		end
		// Masking keeps reserved bits at zero whatever software writes
		if (psel && penable && pwrite && hit) begin
			next_cfg[idx] = pwdata & (idx[1] ? nscw_pkg::MASK_AREA45 : nscw_pkg::MASK_AREA23);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < 4; i++) begin
				cfg[i] <= nscw_pkg::RST_WAIT;
			end
			prdata <= 32'h0000_0000;
		end else begin
			for (int i = 0; i < 4; i++) begin
				cfg[i] <= next_cfg[i];
			end
			prdata <= next_prdata;
		end
	end

	assign pready = 1'b1;
	assign pslverr = psel && penable && !hit && !(paddr == nscw_pkg::OFF_STATUS && !pwrite);

	// ==================================================
	// Access sequencer
	logic [31:0] sel;
	logic take;
	logic [nscw_pkg::CNT_W-1:0] wait_cycles, wait_count, setup_count;
	logic wait_zero, honour;
	logic [1:0] setup_code;

	assign sel = cfg[acc_area];
	assign take = (state == ST_IDLE) && acc_req;
	// Areas 2 and 3 have no setup field: fixed half cycle
	assign setup_code = acc_area[1] ? sel[nscw_pkg::SW_LSB +: 2] : 2'h0;
	assign honour = !lat_mask && !ext_wait_n;

	nscw_wait_decode u_decode (
		.wr_code(sel[nscw_pkg::WR_LSB +: 4]),
		.ww_code(sel[nscw_pkg::WW_LSB +: 3]),
		.use_ww(acc_write && acc_area[1]),
		.cycles(wait_cycles)
	);

	nscw_down_counter #(.W(nscw_pkg::CNT_W)) u_wait_cnt (
		.pclk(pclk),
		.presetn(presetn),
		.load(take),
		.load_val(wait_cycles),
		.dec(state == ST_STROBE),
		.count(wait_count),
		.zero(wait_zero)
	);

	nscw_down_counter #(.W(nscw_pkg::CNT_W)) u_setup_cnt (
		.pclk(pclk),
		.presetn(presetn),
		.load(take),
		.load_val({3'h0, setup_code}),
		.dec(state == ST_SETUP),
		.count(setup_count),
		.zero()
	);

	always_comb begin
		next_state = state;
		next_area = lat_area;
		next_write = lat_write;
		next_mask = lat_mask;
		next_setup = lat_setup;
		case (state)
			ST_IDLE: begin
				if (take) begin
					next_area = acc_area;
					next_write = acc_write;
					next_mask = sel[nscw_pkg::WM_BIT];
					next_setup = setup_code;
					next_state = (setup_code == 2'h0) ? ST_STROBE : ST_SETUP;
				end
			end
			ST_SETUP: begin
				if (setup_count == 5'h01) begin
					next_state = ST_STROBE;
				end
			end
			ST_STROBE: begin
				if (wait_zero) begin
					next_state = honour ? ST_EXTWAIT : ST_END;
				end
			end
			ST_EXTWAIT: begin
				if (ext_wait_n) begin
					next_state = ST_END;
				end
			end
			ST_END: next_state = ST_IDLE;
			default: next_state = ST_IDLE;
		endcase
	end

	// ==================================================
	// Pin drivers
	logic [3:0] next_cs_n;
	logic [AW-1:0] next_addr;
	logic [DW-1:0] next_wdata, next_rdata;
	logic next_oe_n, strobing, next_rd_n, next_we_n;

	always_comb begin
		next_cs_n = (next_state == ST_IDLE) ? 4'hF : ~(4'h1 << next_area);
		next_addr = take ? acc_addr : ext_addr;
		next_wdata = (take && acc_write) ? acc_wdata : ext_data_o;
		next_oe_n = !(next_state != ST_IDLE && next_write);
		next_rdata = acc_rdata;
		if (!lat_write && next_state == ST_END && (state == ST_STROBE || state == ST_EXTWAIT)) begin
			next_rdata = ext_data_i;
		end
		strobing = (state == ST_STROBE) || (state == ST_EXTWAIT);
		next_rd_n = !(strobing && !lat_write);
		next_we_n = !(strobing && lat_write);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= ST_IDLE;
			lat_area <= 2'h0;
			lat_write <= 1'b0;
			lat_mask <= 1'b0;
			lat_setup <= 2'h0;
			area_chip_select_n <= 4'hF;
			ext_addr <= '0;
			ext_data_o <= '0;
			ext_data_oe_n <= 1'b1;
			acc_rdata <= '0;
		end else begin
			state <= next_state;
			lat_area <= next_area;
			lat_write <= next_write;
			lat_mask <= next_mask;
			lat_setup <= next_setup;
			area_chip_select_n <= next_cs_n;
			ext_addr <= next_addr;
			ext_data_o <= next_wdata;
			ext_data_oe_n <= next_oe_n;
			acc_rdata <= next_rdata;
		end
	end

	// Falling edge launch gives the half-cycle offset from chip select
	always_ff @(negedge pclk or negedge presetn) begin
		if (!presetn) begin
			ext_rd_n <= 1'b1;
			ext_we_n <= 1'b1;
		end else begin
			ext_rd_n <= next_rd_n;
			ext_we_n <= next_we_n;
		end
	end

	assign acc_ready = (state == ST_IDLE);
	assign acc_done = (state == ST_END);

	// ==================================================
	// Checks
	logic [5:0] strobe_cycles;
	logic [2:0] pre_cnt;
	logic [nscw_pkg::CNT_W-1:0] lat_wait;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			strobe_cycles <= 6'h00;
			pre_cnt <= 3'h0;
			lat_wait <= '0;
		end else begin
			strobe_cycles <= (state == ST_STROBE) ? strobe_cycles + 6'h01 : 6'h00;
			pre_cnt <= (state == ST_SETUP) ? pre_cnt + 3'h1 : 3'h0;
			lat_wait <= take ? wait_cycles : lat_wait;
		end
	end

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	chk_reserved_zero: assert property ((((cfg[0] | cfg[1]) & ~nscw_pkg::MASK_AREA23) == 32'h0)
		&& (((cfg[2] | cfg[3]) & ~nscw_pkg::MASK_AREA45) == 32'h0))
		else $error("reserved bit set");
	chk_wait_len: assert property (state == ST_STROBE && next_state != ST_STROBE |-> strobe_cycles == 6'(lat_wait))
		else $error("strobe length differs from wait count");
	chk_wait_decode: assert property (take && !acc_area[1] && sel[10:7] == 4'hA |=> lat_wait == 5'h0E)
		else $error("code 1010 not 14 cycles");
	chk_ww_decode: assert property (take && acc_area[1] && acc_write && sel[18:16] == 3'h7 |=> lat_wait == 5'h06)
		else $error("write wait code 111 not 6 cycles");
	chk_ext_honour: assert property (state == ST_STROBE && wait_zero && !lat_mask && !ext_wait_n |=> state == ST_EXTWAIT)
		else $error("external wait not honoured");
	chk_ext_mask: assert property (state == ST_EXTWAIT |-> !lat_mask)
		else $error("masked wait extended access");
	chk_setup_len: assert property ($rose(state == ST_STROBE) |-> pre_cnt == {1'h0, lat_setup})
		else $error("setup delay wrong");
	chk_strobe_in_cs: assert property (!(ext_rd_n && ext_we_n) |-> area_chip_select_n != 4'hF && !(!ext_rd_n && !ext_we_n))
		else $error("strobe outside chip select");

	cov_ext_wait: cover property (state == ST_EXTWAIT ##1 state == ST_END);
	cov_long_setup: cover property ($rose(state == ST_STROBE) && lat_setup == 2'h3);
	cov_write_done: cover property (acc_done && lat_write);
endmodule
`default_nettype wire

// ### testbench/nscw_sram_model.sv
// Behavioural external memory with a programmable wait stall
`timescale 1ns/10ps
`default_nettype none
module nscw_sram_model (
	// Bus side
	input wire logic pclk,
	input wire logic [3:0] cs_n,
	input wire logic [23:0] addr,
	input wire logic rd_n,
	input wire logic we_n,
	input wire logic oe_n,
	input wire logic [15:0] wdata,
	input wire logic [3:0] hold,
	// Answers
	output logic [15:0] rdata,
	output logic wait_n,
	output logic strobe_err
);
	logic [15:0] mem [0:15];
	logic [15:0] last;
	logic [3:0] cnt;
	initial begin
		strobe_err = 1'b0;
		cnt = 4'h0;
		last = 16'h0000;
	end
	// ==========
	// Data only while strobed; a toggling pattern otherwise
	always_comb rdata = (!rd_n && cs_n != 4'hF) ? mem[addr[3:0]] : ~last;
	always @(posedge pclk) last <= rdata;
	always @(posedge we_n) if (cs_n != 4'hF && !oe_n) mem[addr[3:0]] <= wdata;
	// ==========
	// Stall for hold cycles once a strobe is seen
	always @(posedge pclk) cnt <= (rd_n && we_n) ? 4'h0 : cnt + 4'h1;
	assign wait_n = !(!(rd_n && we_n) && cnt < hold);
	// Strobes must move only while the clock is low
	always @(rd_n or we_n) if (pclk === 1'b1 && $time > 0) strobe_err <= 1'b1;
endmodule
`default_nettype wire

// ### testbench/normal_space_wait_cycle_config_test.sv
// Self-checking bench for the wait-cycle controller
`timescale 1ns/10ps
`default_nettype none
module normal_space_wait_cycle_config_test;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic acc_req, acc_write, acc_ready, acc_done, rd_n, we_n, oe_n, wait_n, s_err;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [1:0] acc_area;
	logic [23:0] acc_addr, ext_addr;
	logic [15:0] acc_wdata, acc_rdata, d_o, d_i, r16;
	logic [3:0] cs_n, hold;
	int n_mismatch, cmp_count, n;
	int wr_tab [13] = '{0, 1, 2, 3, 4, 5, 6, 8, 10, 12, 14, 18, 24};
	nscw_ctrl nscw_ctrl_i (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .acc_req(acc_req), .acc_area(acc_area), .acc_write(acc_write),
		.acc_addr(acc_addr), .acc_wdata(acc_wdata), .acc_ready(acc_ready), .acc_done(acc_done),
		.acc_rdata(acc_rdata), .ext_addr(ext_addr), .area_chip_select_n(cs_n), .ext_rd_n(rd_n),
		.ext_we_n(we_n), .ext_data_o(d_o), .ext_data_oe_n(oe_n), .ext_data_i(d_i), .ext_wait_n(wait_n));
	nscw_sram_model nscw_sram_model_i (.pclk(pclk), .cs_n(cs_n), .addr(ext_addr), .rd_n(rd_n),
		.we_n(we_n), .oe_n(oe_n), .wdata(d_o), .hold(hold), .rdata(d_i), .wait_n(wait_n),
		.strobe_err(s_err));
	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end
	// ==========
	// Shared tasks
	task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			$display("BAD %s expected %h seen %h", nm, exp, got);
			n_mismatch++;
		end
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// Count of clock cycles from the take edge to the done cycle
	task acc(input logic [1:0] ar, input logic w, input logic [23:0] a, input logic [15:0] d);
		@(posedge pclk);
		acc_req <= 1'b1;
		acc_area <= ar;
		acc_write <= w;
		acc_addr <= a;
		acc_wdata <= d;
		do @(negedge pclk); while (acc_ready !== 1'b1);
		@(posedge pclk);
		acc_req <= 1'b0;
		n = 0;
		do begin
			@(negedge pclk);
			n++;
		end while (acc_done !== 1'b1 && n < 200);
		r16 = acc_rdata;
		@(posedge pclk);
	endtask
	task wrap_up;
		$display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	// Far more than the run needs
	initial begin
		#200000;
		n_mismatch++;
		wrap_up;
	end
	// ==========
	// Tests
	initial begin
		{presetn, psel, penable, pwrite, acc_req, acc_write} = 6'h00;
		{paddr, pwdata, acc_area, acc_addr, acc_wdata, hold} = '0;
		n_mismatch = 0;
		cmp_count = 0;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 4; i++) begin
			apb(1'b0, 8'(4 * i), 32'h0);
			chk("reset value", 32'h0000_0500, rd);
			// Bit 10 held low so the wait code stays a legal one
			apb(1'b1, 8'(4 * i), 32'hFFFF_FBFF);
			apb(1'b0, 8'(4 * i), 32'h0);
			chk("reserved bits", i < 2 ? 32'h0000_03C0 : 32'h0007_1BC0, rd);
		end
		apb(1'b0, 8'h14, 32'h0);
		chk("unmapped error", 32'h1, {31'h0, err});
		apb(1'b0, nscw_pkg::OFF_STATUS, 32'h0);
		chk("status idle", 32'h0, rd);
		chk("status read error", 32'h0, {31'h0, err});
		apb(1'b1, nscw_pkg::OFF_STATUS, 32'h0);
		chk("status write error", 32'h1, {31'h0, err});
		$display("test registers done");
		for (int c = 0; c < 13; c++) begin
			apb(1'b1, 8'(4 * (c % 2)), (32'(c) << 7) | 32'h0000_0040);
			acc(2'(c % 2), 1'b0, 24'h0, 16'h0);
			chk("access wait", 32'(wr_tab[c] + 2), 32'(n));
		end
		$display("test wait table done");
		hold <= 4'h3;
		apb(1'b1, nscw_pkg::OFF_AREA2, 32'h0000_0000);
		acc(2'd0, 1'b0, 24'h0, 16'h0);
		chk("ext wait honoured", 32'h5, 32'(n));
		apb(1'b1, nscw_pkg::OFF_AREA2, 32'h0000_0040);
		acc(2'd0, 1'b0, 24'h0, 16'h0);
		chk("ext wait masked", 32'h2, 32'(n));
		hold <= 4'h0;
		$display("test external wait done");
		for (int k = 0; k < 8; k++) begin
			apb(1'b1, nscw_pkg::OFF_AREA4, (32'(k) << 16) | 32'h0000_0140);
			acc(2'd2, 1'b1, 24'(k), 16'hA500 + 16'(k));
			chk("write wait", k == 0 ? 32'h4 : 32'(k + 1), 32'(n));
		end
		$display("test write wait done");
		for (int s = 0; s < 4; s++) begin
			apb(1'b1, nscw_pkg::OFF_AREA5A, (32'(s) << 11) | 32'h0000_00C0);
			acc(2'd3, 1'b0, 24'(s), 16'h0);
			chk("setup delay", 32'(s + 3), 32'(n));
			chk("read data", {16'h0, 16'hA500 + 16'(s)}, {16'h0, r16});
		end
		chk("strobe on falling edge", 32'h0, {31'h0, s_err});
		$display("test setup delay done");
		wrap_up;
	end
endmodule
`default_nettype wire
